// >>> logic/dmsp_map.vh
// register map, field positions, reset values and timing counts of the serial port pair
`ifndef DMSP_MAP_VH
`define DMSP_MAP_VH
// byte offsets inside one port window; port n sits at n * DMSP_PORT_STRIDE
`define DMSP_PORT_STRIDE 32'h00000010
`define DMSP_OFS_CTRL 4'h0
`define DMSP_OFS_DATA 4'h4
`define DMSP_OFS_BAUD 4'h8
// control register fields
`define DMSP_CTRL_RXF 0
`define DMSP_CTRL_TXF 1
`define DMSP_CTRL_RX9 2
`define DMSP_CTRL_TX9 3
`define DMSP_CTRL_REN 4
`define DMSP_CTRL_MPE 5
`define DMSP_CTRL_MSH 6
`define DMSP_CTRL_MSL 7
// baud register fields: reload value in [7:0], doubling bit
`define DMSP_BAUD_DBL 8
// reset values
`define DMSP_CTRL_RST 8'h00
`define DMSP_BAUD_RST 9'h000
// mode codes {mode_sel_lo, mode_sel_hi}
`define DMSP_MODE_SHIFT 2'h0
`define DMSP_MODE_ASYNC8 2'h1
`define DMSP_MODE_FIXED9 2'h2
`define DMSP_MODE_VAR9 2'h3
// timing counts: hclk cycles (hclk is the oscillator) for the first five, baud ticks for the last two
`define DMSP_M0_DIV 4'hc
`define DMSP_M0_HALF 4'h6
`define DMSP_T1_PRESCALE 4'hc
`define DMSP_M2_TICK_SLOW 2'h3
`define DMSP_M2_TICK_FAST 2'h1
`define DMSP_MID_TICK 4'h7
`define DMSP_LAST_TICK 4'hf
`endif

// >>> logic/dmsp_top.v
// two identical four-mode serial ports behind an ahb-lite register slave
//
// Notes on behaviour
// - modes 1-3: transmitter and receiver run independently, full duplex
// - receive buffered; unread byte makes new lost
// - data write loads transmitter; read returns receive buffer
// - mode 0: rxd data both ways, txd clock/12
// - mode 1: start, eight bits lsb first, stop
// - mode 1 receive stores stop in ninth bit
// - modes 2,3: eleven bits, ninth from tx_ninth_bit
// - modes 2,3 store ninth bit, ignore stop
// - mode 2 rate is oscillator/32 or /64
// - mode 3 frames like mode 2, variable rate
// - every mode: data write starts transmission
// - mode 0 receive starts on flag clear, enabled
// - async receive starts on start bit, enabled
// - multiproc set: flag only when ninth bit one
// - multiproc enable ignored in mode 0
// - mode 1 multiproc: flag only on valid stop
// - two ports, each with own registers
// - tx flag set at bit eight or stop start
// - rx flag set at bit eight or mid stop
// - mode code zero is shift register mode
// - variable rate: timer overflow times 2^dbl / 32
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dmsp_map.vh"

module dmsp_top (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // serial pins, one bit per port
    input wire [1:0] rxd_in,
    output wire [1:0] rxd_out,
    output wire [1:0] rxd_out_en_n,
    output wire [1:0] txd
);

////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait state so that read data leaves a flip-flop

reg ph_act;
reg ph_wr;
reg ph_map;
reg [4:0] ph_addr;
wire [15:0] ctrl_all;
wire [15:0] data_all;
wire [17:0] baud_all;
wire ph_port;
wire [3:0] ph_ofs;
reg [31:0] next_rdata;

assign ph_port = ph_addr[4];
assign ph_ofs = ph_addr[3:0];

// read mux; unmapped addresses and reserved bits read zero
always @* begin
    next_rdata = 32'h00000000;
    if (ph_map && ph_ofs == `DMSP_OFS_CTRL)
        next_rdata = {24'h000000, ctrl_all[ph_port*8 +: 8]};
    else if (ph_map && ph_ofs == `DMSP_OFS_DATA)
        next_rdata = {24'h000000, data_all[ph_port*8 +: 8]};
    else if (ph_map && ph_ofs == `DMSP_OFS_BAUD)
        next_rdata = {23'h000000, baud_all[ph_port*9 +: 9]};
end

// address phase capture, then answer okay after one wait cycle
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ph_act <= 1'b0;
        ph_wr <= 1'b0;
        ph_map <= 1'b0;
        ph_addr <= 5'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= 32'h00000000;
    end else if (hsel && htrans[1] && hready) begin
        ph_act <= 1'b1;
        ph_wr <= hwrite;
        ph_map <= (haddr[31:5] == 27'h0000000) && (haddr[3:2] != 2'h3)
                  && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
        ph_addr <= haddr[4:0];
        hreadyout <= 1'b0;
    end else if (ph_act) begin
        ph_act <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= next_rdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// two identical ports

genvar p;
generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
        wire sel;
        wire wr_ctrl;
        wire wr_data;
        wire wr_baud;
        wire [1:0] mode;
        wire tick;
        reg [7:0] ctrl;
        reg [7:0] rx_buf;
        reg [8:0] baud;
        // pulses from the engines into the register block
        reg set_txf;
        reg set_rxf;
        reg [8:0] ld_val;
        // baud generation
        reg [3:0] pre;
        reg [7:0] tmr;
        reg half;
        reg [1:0] m2cnt;
        wire ovf;
        // transmit and mode 0 engine
        reg tx_busy;
        reg [9:0] tx_sh;
        reg [3:0] tx_rem;
        reg [3:0] tx_tk;
        reg txd_q;
        reg m0_busy;
        reg m0_rx;
        reg [3:0] m0_div;
        reg [2:0] m0_n;
        reg [7:0] m0_sh;
        reg rxo_q;
        reg rxoe_n_q;
        // async receiver
        reg [1:0] rx_st;
        reg [3:0] rx_tk;
        reg [3:0] rx_n;
        reg [8:0] rx_sh;
        reg rx_prev;
        wire [8:0] rx_frame;

        assign sel = ph_act && ph_wr && ph_map && (ph_port == p);
        assign wr_ctrl = sel && (ph_ofs == `DMSP_OFS_CTRL);
        assign wr_data = sel && (ph_ofs == `DMSP_OFS_DATA);
        assign wr_baud = sel && (ph_ofs == `DMSP_OFS_BAUD);
        assign mode = {ctrl[`DMSP_CTRL_MSL], ctrl[`DMSP_CTRL_MSH]};
        assign ctrl_all[p*8 +: 8] = ctrl;
        assign data_all[p*8 +: 8] = rx_buf;
        assign baud_all[p*9 +: 9] = baud;
        assign txd[p] = txd_q;
        assign rxd_out[p] = rxo_q;
        assign rxd_out_en_n[p] = rxoe_n_q;

        // timer overflow every 12*(256-reload) clocks; tick is 16x the bit rate
        assign ovf = (pre == `DMSP_T1_PRESCALE - 4'h1) && (tmr == 8'hff);
        assign tick = (mode == `DMSP_MODE_FIXED9) ?
                      (m2cnt == (baud[`DMSP_BAUD_DBL] ? `DMSP_M2_TICK_FAST
                                                        : `DMSP_M2_TICK_SLOW)) :
                      (ovf && (baud[`DMSP_BAUD_DBL] || half));
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pre <= 4'h0;
                tmr <= 8'h00;
                half <= 1'b0;
                m2cnt <= 2'h0;
            end else begin
                pre <= (pre == `DMSP_T1_PRESCALE - 4'h1) ? 4'h0 : pre + 4'h1;
                if (ovf) begin
                    tmr <= baud[7:0];
                    half <= ~half;
                end else if (pre == `DMSP_T1_PRESCALE - 4'h1) begin
                    tmr <= tmr + 8'h01;
                end
                m2cnt <= tick ? 2'h0 : m2cnt + 2'h1;
            end
        end

        // software registers; a hardware set wins over a clearing write
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl <= `DMSP_CTRL_RST;
                baud <= `DMSP_BAUD_RST;
                rx_buf <= 8'h00;
            end else begin
                if (wr_ctrl)
                    ctrl <= hwdata[7:0];
                if (wr_baud)
                    baud <= hwdata[8:0];
                if (set_txf)
                    ctrl[`DMSP_CTRL_TXF] <= 1'b1;
                if (set_rxf) begin
                    ctrl[`DMSP_CTRL_RXF] <= 1'b1;
                    ctrl[`DMSP_CTRL_RX9] <= ld_val[8];
                    rx_buf <= ld_val[7:0];
                end
            end
        end

        // transmitter plus the half-duplex mode 0 shifter
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tx_busy <= 1'b0;
                tx_sh <= 10'h000;
                tx_rem <= 4'h0;
                tx_tk <= 4'h0;
                txd_q <= 1'b1;
                m0_busy <= 1'b0;
                m0_rx <= 1'b0;
                m0_div <= 4'h0;
                m0_n <= 3'h0;
                m0_sh <= 8'h00;
                rxo_q <= 1'b1;
                rxoe_n_q <= 1'b1;
                set_txf <= 1'b0;
            end else begin
                set_txf <= 1'b0;
                if (wr_data && mode == `DMSP_MODE_SHIFT) begin
                    m0_busy <= 1'b1;
                    m0_rx <= 1'b0;
                    m0_div <= 4'h0;
                    m0_n <= 3'h0;
                    m0_sh <= hwdata[7:0];
                    rxo_q <= hwdata[0];
                    rxoe_n_q <= 1'b0;
                    txd_q <= 1'b0;
                end else if (wr_data) begin
                    tx_busy <= 1'b1;
                    tx_tk <= 4'h0;
                    txd_q <= 1'b0; // start bit
                    if (mode == `DMSP_MODE_ASYNC8) begin
                        tx_sh <= {2'h3, hwdata[7:0]};
                        tx_rem <= 4'h9;
                    end else begin
                        tx_sh <= {1'b1, ctrl[`DMSP_CTRL_TX9], hwdata[7:0]};
                        tx_rem <= 4'ha;
                    end
                end else if (!m0_busy && !set_rxf && mode == `DMSP_MODE_SHIFT
                             && ctrl[`DMSP_CTRL_REN] && !ctrl[`DMSP_CTRL_RXF]) begin
                    m0_busy <= 1'b1;
                    m0_rx <= 1'b1;
                    m0_div <= 4'h0;
                    m0_n <= 3'h0;
                    rxoe_n_q <= 1'b1;
                    txd_q <= 1'b0;
                end else if (m0_busy) begin
                    // clock low for six cycles, high for six; data sampled before the rise
                    m0_div <= (m0_div == `DMSP_M0_DIV - 4'h1) ? 4'h0 : m0_div + 4'h1;
                    if (m0_div == `DMSP_M0_HALF - 4'h1) begin
                        txd_q <= 1'b1;
                        if (m0_rx)
                            m0_sh <= {rxd_in[p], m0_sh[7:1]};
                    end
                    if (m0_div == `DMSP_M0_DIV - 4'h1) begin
                        m0_n <= m0_n + 3'h1;
                        m0_sh <= m0_rx ? m0_sh : {1'b0, m0_sh[7:1]};
                        rxo_q <= m0_rx ? 1'b1 : m0_sh[1];
                        if (m0_n == 3'h7) begin
                            m0_busy <= 1'b0;
                            rxoe_n_q <= 1'b1;
                            rxo_q <= 1'b1;
                            set_txf <= ~m0_rx;
                        end else begin
                            txd_q <= 1'b0;
                        end
                    end
                end else if (tx_busy && tick) begin
                    tx_tk <= tx_tk + 4'h1;
                    if (tx_tk == `DMSP_LAST_TICK) begin
                        if (tx_rem == 4'h0) begin
                            tx_busy <= 1'b0;
                            txd_q <= 1'b1;
                        end else begin
                            txd_q <= tx_sh[0]; // lsb first
                            tx_sh <= {1'b1, tx_sh[9:1]};
                            tx_rem <= tx_rem - 4'h1;
                            set_txf <= (tx_rem == 4'h1);
                        end
                    end
                end
            end
        end

        // mode 1 keeps the stop bit as ninth bit; modes 2 and 3 keep the ninth data bit
        assign rx_frame = (mode == `DMSP_MODE_ASYNC8) ? {rxd_in[p], rx_sh[8:1]} : rx_sh;

        // async receiver with its own shift register, separate from rx_buf
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                rx_st <= 2'h0;
                rx_tk <= 4'h0;
                rx_n <= 4'h0;
                rx_sh <= 9'h000;
                rx_prev <= 1'b1;
                set_rxf <= 1'b0;
                ld_val <= 9'h000;
            end else begin
                rx_prev <= rxd_in[p];
                set_rxf <= 1'b0;
                if (m0_busy && m0_rx && m0_div == `DMSP_M0_DIV - 4'h1 && m0_n == 3'h7) begin
                    set_rxf <= 1'b1;
                    ld_val <= {ctrl[`DMSP_CTRL_RX9], m0_sh};
                end
                case (rx_st)
                    2'h0: begin
                        if (rx_prev && !rxd_in[p] && ctrl[`DMSP_CTRL_REN]
                            && mode != `DMSP_MODE_SHIFT) begin
                            rx_st <= 2'h1;
                            rx_tk <= 4'h0;
                        end
                    end
                    2'h1: begin
                        if (tick) begin
                            rx_tk <= rx_tk + 4'h1;
                            if (rx_tk == `DMSP_MID_TICK) begin
                                rx_st <= rxd_in[p] ? 2'h0 : 2'h2;
                                rx_n <= 4'h0;
                            end
                        end
                    end
                    2'h2: begin
                        if (tick) begin
                            rx_tk <= rx_tk + 4'h1;
                            if (rx_tk == `DMSP_MID_TICK) begin
                                rx_n <= rx_n + 4'h1;
                                rx_sh <= {rxd_in[p], rx_sh[8:1]};
                                if (rx_n == ((mode == `DMSP_MODE_ASYNC8) ? 4'h8 : 4'h9)) begin
                                    rx_st <= 2'h0;
                                    // stop bit ignored in modes 2, 3; unread byte keeps
                                    if (!ctrl[`DMSP_CTRL_RXF]
                                        && (!ctrl[`DMSP_CTRL_MPE] || rx_frame[8])) begin
                                        set_rxf <= 1'b1;
                                        ld_val <= rx_frame;
                                    end
                                end
                            end
                        end
                    end
                    default: rx_st <= 2'h0;
                endcase
            end
        end
    end
endgenerate

endmodule // dmsp_top

// >>> dv/dmsp_top_assertions.sv
// assertion checker for the serial port pair at its top-level ports
`timescale 1ns/1ps

module dmsp_checker (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // serial pins
    input wire [1:0] rxd_out,
    input wire [1:0] rxd_out_en_n,
    input wire [1:0] txd
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic txd_q;
    logic [4:0] nfall;
    ////////////////////////////////////////
    // count shift clock falls of one port 0 mode 0 transmit; own delay avoids clock inference
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_q <= 1'b1;
            nfall <= 5'h00;
        end else begin
            txd_q <= txd[0];
            if (rxd_out_en_n[0])
                nfall <= 5'h00;
            else if (txd_q && !txd[0])
                nfall <= nfall + 5'h01;
        end
    end
    ////////////////////////////////////////
    property p_one_wait;
        hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("no single wait state");
    property p_wait_cause;
        $fell(hreadyout) |-> $past(hsel) && $past(htrans[1]) && $past(hready);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rdata_hold;
        $changed(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_m0_low;
        $fell(txd[0]) && !rxd_out_en_n[0] |-> !txd[0] [*6] ##1 txd[0];
    endproperty
    a_m0_low: assert property (p_m0_low) else $error("shift clock low phase wrong");
    property p_m0_high;
        $rose(txd[0]) && !rxd_out_en_n[0] |-> txd[0] [*6];
    endproperty
    a_m0_high: assert property (p_m0_high) else $error("shift clock high phase short");
    property p_m0_hold;
        !rxd_out_en_n[0] && !$past(rxd_out_en_n[0]) && !$fell(txd[0]) |-> $stable(rxd_out[0]);
    endproperty
    a_m0_hold: assert property (p_m0_hold) else $error("shift data moved off clock fall");
    property p_m0_count;
        $rose(rxd_out_en_n[0]) |-> nfall == 5'h08;
    endproperty
    a_m0_count: assert property (p_m0_count) else $error("shift transmit not eight bits");
    // main scenarios reached
    c_m0_tx: cover property ($fell(rxd_out_en_n[0]));
    c_async_tx: cover property ($fell(txd[1]) && rxd_out_en_n[1]);
    c_read: cover property ($changed(hrdata));
endmodule // dmsp_checker

bind dmsp_top dmsp_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rxd_out(rxd_out), .rxd_out_en_n(rxd_out_en_n), .txd(txd));

// >>> dv/dmsp_remote.sv
// far-end serial device model: async frame source and sink, mode 0 shift slave
`timescale 1ns/1ps

module dmsp_remote (
    // clock
    input wire hclk,
    // serial pins seen from the far end
    input wire txd,
    input wire rxd_out,
    input wire rxd_out_en_n,
    output wire rxd_in
);
    logic drv = 1'b1;
    logic m0 = 1'b0;
    logic [7:0] m0_src = 8'h00;
    logic [7:0] m0_got = 8'h00;
    logic [3:0] m0_idx = 4'h0;
    // the port owns the data line while it drives it, else our pulled-up driver does
    assign rxd_in = rxd_out_en_n ? drv : rxd_out;
    // mode 0: next bit on the falling shift clock, so it is settled by the rise
    always @(negedge txd) begin
        if (m0 && m0_idx < 4'h8) begin
            drv <= m0_src[m0_idx[2:0]];
            m0_idx <= m0_idx + 4'h1;
        end
    end
    // capture on the rising shift clock; back to idle high after bit eight
    always @(posedge txd) begin
        if (m0) begin
            m0_got <= {rxd_in, m0_got[7:1]};
            if (m0_idx == 4'h8)
                drv <= 1'b1;
        end
    end
    // arm the shift slave with the byte it hands out
    task automatic arm(input logic [7:0] src);
        m0 = 1'b1;
        m0_src = src;
        m0_idx = 4'h0;
        drv = 1'b1;
    endtask
    // send nb bits of f, lsb first, each bit per clocks long
    task automatic send(input logic [10:0] f, input int nb, input int per);
        @(posedge hclk);
        for (int i = 0; i < nb; i++) begin
            drv <= f[i];
            repeat (per) @(posedge hclk);
        end
        drv <= 1'b1;
    endtask
    // sample a frame from txd in the middle of each bit
    task automatic get(input int nb, input int per, output logic [10:0] f);
        f = 11'h000;
        @(negedge txd);
        repeat (per / 2) @(posedge hclk);
        for (int i = 0; i < nb; i++) begin
            f[i] = txd;
            if (i < nb - 1)
                repeat (per) @(posedge hclk);
        end
    endtask
endmodule // dmsp_remote

// >>> dv/testbench.sv
// self-checking bench for the serial port pair: bus, async frames and mode 0
`timescale 1ns/1ps

module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] seed = 32'h0001703d;
    wire hready;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire [1:0] rxd_in;
    wire [1:0] rxd_out;
    wire [1:0] rxd_out_en_n;
    wire [1:0] txd;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    dmsp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_out_en_n(rxd_out_en_n), .txd(txd));
    dmsp_remote rem0 (.hclk(hclk), .txd(txd[0]), .rxd_out(rxd_out[0]),
        .rxd_out_en_n(rxd_out_en_n[0]), .rxd_in(rxd_in[0]));
    dmsp_remote rem1 (.hclk(hclk), .txd(txd[1]), .rxd_out(rxd_out[1]),
        .rxd_out_en_n(rxd_out_en_n[1]), .rxd_in(rxd_in[1]));
    ////////////////////////////////////////
    // free-running clock and hang guard
    initial forever #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // frame bits lsb first; ten-bit frames leave the top bit zero
    function automatic logic [10:0] mk(input logic [7:0] d, input logic n9, input logic stp,
        input int nb);
        return (nb == 11) ? {stp, n9, d, 1'b0} : {1'b0, stp, d, 1'b0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    ////////////////////////////////////////
    // one single-word transfer; wait for ready at both phases, no cycle count assumed
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] x;
        bus(1'b0, a, 32'h00000000, x);
        chk("register", e, x & m);
    endtask
    task automatic rsend(input int p, input logic [10:0] f, input int nb, input int per);
        if (p == 1)
            rem1.send(f, nb, per);
        else
            rem0.send(f, nb, per);
    endtask
    task automatic rget(input int p, input int nb, input int per, output logic [10:0] f);
        if (p == 1)
            rem1.get(nb, per, f);
        else
            rem0.get(nb, per, f);
    endtask
    // full-duplex async exchange: send d in, transmit a random byte out, check both ends
    task automatic async(input int p, input logic [1:0] md, input logic dbl,
        input logic [7:0] d, input logic b9, input logic stp, input logic mpe,
        input logic ren, input logic expri);
        logic [10:0] got;
        logic [7:0] td;
        logic r9;
        int nb;
        int per;
        nb = (md == 2'h1) ? 10 : 11;
        per = (md == 2'h2) ? (dbl ? 32 : 64) : (dbl ? 192 : 384);
        r9 = expri ? ((nb == 10) ? stp : b9) : 1'b0;
        seed = nxt(seed);
        td = seed[7:0];
        wr(p * 16 + 8, {23'h0, dbl, 8'hff});
        wr(p * 16, {24'h0, md, mpe, ren, ~b9, 3'h0});
        fork
            wr(p * 16 + 4, {24'h0, td});
            rsend(p, mk(d, b9, stp, nb), nb, per);
            rget(p, nb, per, got);
        join
        repeat (4) @(posedge hclk);
        chk("tx frame", {21'h0, mk(td, ~b9, 1'b1, nb)}, {21'h0, got});
        rdchk(p * 16, {29'h0, r9, 1'b1, expri}, 32'h7);
        if (expri)
            rdchk(p * 16 + 4, {24'h0, d}, 32'hff);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 32; a += 4)
            rdchk(a, 32'h0, 32'hffffffff);
        wr(32'h0c, 32'hffffffff);
        rdchk(32'h0c, 32'h0, 32'hffffffff);
        // random mode 2 traffic over both ports and both rates; stop bit random
        for (int i = 0; i < 8; i++) begin
            seed = nxt(seed);
            async(i % 2, 2'h2, i[1], seed[15:8], seed[16], seed[17], 1'b0, 1'b1, 1'b1);
        end
        // second byte completes while the flag is still set: it is lost
        async(0, 2'h2, 1'b1, 8'h96, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        rsend(0, mk(8'h69, 1'b1, 1'b1, 11), 11, 32);
        repeat (4) @(posedge hclk);
        rdchk(4, 32'h96, 32'hff);
        // address byte passes the filter, data byte does not
        async(0, 2'h2, 1'b1, 8'h5a, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
        async(0, 2'h2, 1'b1, 8'ha5, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        async(1, 2'h3, 1'b1, 8'h3c, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        async(1, 2'h1, 1'b1, 8'hc7, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        async(0, 2'h1, 1'b1, 8'h81, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        async(0, 2'h1, 1'b1, 8'h7e, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        async(1, 2'h2, 1'b1, 8'h44, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        // mode 0 transmit of a random byte on port 1
        seed = nxt(seed);
        rem1.arm(8'h00);
        wr(32'h10, 32'h0);
        wr(32'h14, {24'h0, seed[7:0]});
        repeat (104) @(posedge hclk);
        chk("shift out 1", {24'h0, seed[7:0]}, {24'h0, rem1.m0_got});
        rdchk(32'h10, 32'h2, 32'h7);
        // mode 0 transmit then receive on port 0, multiprocessor bit set on receive
        rem0.arm(8'h00);
        wr(0, 32'h0);
        wr(4, 32'hc3);
        repeat (104) @(posedge hclk);
        chk("shift out", 32'hc3, {24'h0, rem0.m0_got});
        rdchk(0, 32'h2, 32'h7);
        rem0.arm(8'h5e);
        wr(0, 32'h30);
        repeat (110) @(posedge hclk);
        rdchk(0, 32'h1, 32'h7);
        rdchk(4, 32'h5e, 32'hff);
        // flag still set: no second shift-in may overwrite the buffer
        repeat (100) @(posedge hclk);
        rdchk(4, 32'h5e, 32'hff);
        print_verdict();
    end
endmodule // testbench
